// file: verilog/oscd_top.sv
// Purpose: oscillator select control and system clock divider, APB register slave
// Assumes: config straps and oscillator status arrive asynchronously
// Notes:   zero-wait APB; pready comes one cycle after setup
//
// Decided for this implementation: the register offsets and the APB register port.

`timescale 1ns/100ps
`default_nettype none

module oscd_top (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // nonvolatile configuration straps
  input  wire logic [2:0]                initial_source_config,
  input  wire logic [1:0]                switch_monitor_config,
  // oscillator and monitor status
  input  wire logic                      pll_locked,
  input  wire logic                      switch_done,
  input  wire logic                      fail_safe_monitor_fail,
  // same-clock requests
  input  wire logic                      interrupt_event,
  input  wire logic                      pin_select_write_req,
  // clock tree control
  output logic      [2:0]                current_source_sel,
  output logic      [2:0]                switch_target,
  output logic                           switch_start,
  output logic                           pll_in_use,
  output oscd_pkg::oscd_div_cfg_type     div_cfg,
  output logic                           instr_clk_en,
  output logic                           cpu_clk_en,
  // pin select gate
  output logic                           pin_select_lock,
  output logic                           pin_select_write_grant
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  wire  [6:0] async_in = {switch_done, pll_locked, switch_monitor_config,
                          initial_source_config};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end

  wire [2:0] cfg_source  = sync_b[2:0];
  wire [1:0] cfg_monitor = sync_b[4:3];
  wire       lock_s      = sync_b[5];
  wire       done_s      = sync_b[6];

  // fail input: own two-flop synchroniser, then one stage into the flag logic
  logic fail_a;
  logic fail_s;
  logic fail_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_a <= 1'b0;
      fail_s <= 1'b0;
    end else begin
      fail_a <= fail_safe_monitor_fail;
      fail_s <= fail_a;
    end
  end

  // ---------------------------------------------------------------
  // power-on load of configured source
  // ---------------------------------------------------------------
  logic [1:0] init_cnt;
  logic       init_done;
  wire        init_load = !init_done && (init_cnt == oscd_pkg::OSCD_INIT_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt  <= 2'h0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_cnt  <= init_cnt + 2'h1;
      init_done <= init_load;
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire setup     = psel && !penable;
  wire wr_commit = psel && penable && pwrite && pready;
  wire hit_osc   = (paddr == oscd_pkg::OSCD_OFS_OSC_CTRL);
  wire hit_div   = (paddr == oscd_pkg::OSCD_OFS_CLK_DIV);
  wire hit_key   = (paddr == oscd_pkg::OSCD_OFS_UNLOCK);
  wire mapped    = hit_osc || hit_div || hit_key;
  wire wr_osc    = wr_commit && hit_osc;
  wire wr_div    = wr_commit && hit_div;
  wire wr_key    = wr_commit && hit_key;

  // ---------------------------------------------------------------
  // unlock sequence
  // ---------------------------------------------------------------
  logic key_half;
  logic unlocked;
  wire  key_first  = wr_key && (pwdata[15:0] == oscd_pkg::OSCD_KEY_FIRST);
  wire  key_second = wr_key && key_half && (pwdata[15:0] == oscd_pkg::OSCD_KEY_SECOND);
  wire  osc_wr_ok  = wr_osc && unlocked;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_half <= 1'b0;
      unlocked <= 1'b0;
    end else if (wr_commit) begin
      key_half <= key_first;
      unlocked <= key_second;
    end
  end

  // ---------------------------------------------------------------
  // oscillator control register
  // ---------------------------------------------------------------
  logic [2:0]        requested_source_sel;
  logic              switch_request;
  logic              switch_lock;
  logic              clock_fail_flag;
  oscd_pkg::oscd_sw_state_type sw_state;

  wire switching_on = !cfg_monitor[1];
  wire [2:0] new_req = pwdata[oscd_pkg::OSCD_REQ_LSB +: 3];
  wire cur_pll = (current_source_sel == oscd_pkg::OSCD_SRC_FAST_RC_PLL) ||
                 (current_source_sel == oscd_pkg::OSCD_SRC_PRIMARY_PLL);
  wire req_pll = (new_req == oscd_pkg::OSCD_SRC_FAST_RC_PLL) ||
                 (new_req == oscd_pkg::OSCD_SRC_PRIMARY_PLL);
  wire pll_hop = cur_pll && req_pll && (new_req != current_source_sel);
  wire lock_blocks = switch_lock && (cfg_monitor == oscd_pkg::OSCD_CFG_NOFSM);
  wire req_legal = (new_req != oscd_pkg::OSCD_SRC_RESERVED) && !pll_hop;
  wire sw_grant = osc_wr_ok && pwdata[oscd_pkg::OSCD_SWREQ_BIT] && switching_on &&
                  !lock_blocks && req_legal && (sw_state == oscd_pkg::OSCD_SW_IDLE);
  wire sw_finish = (sw_state == oscd_pkg::OSCD_SW_WAIT) && done_s;
  wire fail_event = fail_seen && (cfg_monitor == oscd_pkg::OSCD_CFG_FULL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      requested_source_sel <= 3'h0;
      switch_lock          <= 1'b0;
      pin_select_lock      <= 1'b0;
    end else if (init_load) begin
      requested_source_sel <= cfg_source;
    end else if (osc_wr_ok) begin
      requested_source_sel <= new_req;
      switch_lock          <= pwdata[oscd_pkg::OSCD_SWLOCK_BIT];
      pin_select_lock      <= pwdata[oscd_pkg::OSCD_PPS_BIT];
    end
  end

  // flag set by monitor wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_seen       <= 1'b0;
      clock_fail_flag <= 1'b0;
    end else begin
      fail_seen <= fail_s;
      if (fail_event) begin
        clock_fail_flag <= 1'b1;
      end else if (osc_wr_ok && !pwdata[oscd_pkg::OSCD_FAIL_BIT]) begin
        clock_fail_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // switch sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state           <= oscd_pkg::OSCD_SW_IDLE;
      switch_request     <= 1'b0;
      switch_start       <= 1'b0;
      switch_target      <= 3'h0;
      current_source_sel <= 3'h0;
    end else begin
      unique case (sw_state)
        oscd_pkg::OSCD_SW_IDLE: begin
          if (init_load) begin
            current_source_sel <= cfg_source;
            switch_target      <= cfg_source;
          end else if (sw_grant) begin
            switch_request <= 1'b1;
            switch_start   <= 1'b1;
            switch_target  <= new_req;
            sw_state       <= oscd_pkg::OSCD_SW_WAIT;
          end
        end
        oscd_pkg::OSCD_SW_WAIT: begin
          if (sw_finish) begin
            current_source_sel <= switch_target;
            switch_request     <= 1'b0;
            switch_start       <= 1'b0;
            sw_state           <= oscd_pkg::OSCD_SW_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_in_use <= 1'b0;
    end else begin
      pll_in_use <= cur_pll;
    end
  end

  wire pll_lock_status = pll_in_use && lock_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_select_write_grant <= 1'b0;
    end else begin
      pin_select_write_grant <= pin_select_write_req && !pin_select_lock;
    end
  end

  // ---------------------------------------------------------------
  // clock divisor register
  // ---------------------------------------------------------------
  logic       recover_on_interrupt;
  logic [2:0] reduction_sel;
  logic       reduction_enable;
  wire  [1:0] new_post = pwdata[oscd_pkg::OSCD_POST_LSB +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recover_on_interrupt <= 1'b0;
      reduction_sel        <= oscd_pkg::OSCD_DOZE_RST;
      div_cfg.rc_postscaler      <= oscd_pkg::OSCD_RCDIV_RST;
      div_cfg.pll_output_divider <= oscd_pkg::OSCD_POST_RST;
      div_cfg.pll_input_divider  <= oscd_pkg::OSCD_PRE_RST;
    end else if (wr_div) begin
      recover_on_interrupt       <= pwdata[oscd_pkg::OSCD_ROI_BIT];
      reduction_sel              <= pwdata[oscd_pkg::OSCD_DOZE_LSB +: 3];
      div_cfg.rc_postscaler      <= pwdata[oscd_pkg::OSCD_RCDIV_LSB +: 3];
      div_cfg.pll_input_divider  <= pwdata[oscd_pkg::OSCD_PRE_LSB +: 5];
      if (new_post != oscd_pkg::OSCD_POST_RSVD) begin
        div_cfg.pll_output_divider <= new_post;
      end
    end
  end

  // interrupt recovery wins over a same-cycle software set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reduction_enable <= 1'b0;
    end else if (interrupt_event && recover_on_interrupt) begin
      reduction_enable <= 1'b0;
    end else if (wr_div) begin
      reduction_enable <= pwdata[oscd_pkg::OSCD_REDUCTION_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // instruction and processor clock enables
  // ---------------------------------------------------------------
  logic       half_phase;
  logic [6:0] doze_cnt;
  wire  [6:0] doze_mask = 7'(({1'b0, 7'h7f}) >> (3'h7 - reduction_sel));
  wire        doze_hit  = !reduction_enable || ((doze_cnt & doze_mask) == doze_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_phase   <= 1'b0;
      instr_clk_en <= 1'b0;
      cpu_clk_en   <= 1'b0;
      doze_cnt     <= 7'h00;
    end else begin
      half_phase   <= !half_phase;
      instr_clk_en <= half_phase;
      cpu_clk_en   <= half_phase && doze_hit;
      if (half_phase) begin
        doze_cnt <= reduction_enable ? doze_cnt + 7'h01 : 7'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux and response
  // ---------------------------------------------------------------
  wire [15:0] osc_word = {1'b0, current_source_sel, 1'b0, requested_source_sel,
                          switch_lock, pin_select_lock, pll_lock_status, 1'b0,
                          clock_fail_flag, 2'b00, switch_request};
  wire [15:0] div_word = {recover_on_interrupt, reduction_sel, reduction_enable,
                          div_cfg.rc_postscaler, div_cfg.pll_output_divider, 1'b0,
                          div_cfg.pll_input_divider};
  wire [31:0] rd_word  = hit_osc ? {16'h0000, osc_word} :
                         hit_div ? {16'h0000, div_word} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

endmodule

`default_nettype wire

// file: shared/oscd_pkg.sv
// Purpose: constants and types for the oscillator select and clock divider block
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   offsets are byte addresses

package oscd_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OSCD_OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OSCD_OFS_CLK_DIV  = 8'h04;
  localparam logic [7:0] OSCD_OFS_UNLOCK   = 8'h08;

  // unlock keys, values arbitrary
  localparam logic [15:0] OSCD_KEY_FIRST  = 16'h00a5;
  localparam logic [15:0] OSCD_KEY_SECOND = 16'h005a;

  // ---------------------------------------------------------------
  // oscillator control fields
  // ---------------------------------------------------------------
  localparam int OSCD_CUR_LSB    = 12;
  localparam int OSCD_REQ_LSB    = 8;
  localparam int OSCD_SWLOCK_BIT = 7;
  localparam int OSCD_PPS_BIT    = 6;
  localparam int OSCD_PLLLK_BIT  = 5;
  localparam int OSCD_FAIL_BIT   = 3;
  localparam int OSCD_SWREQ_BIT  = 0;

  // ---------------------------------------------------------------
  // clock divisor fields
  // ---------------------------------------------------------------
  localparam int OSCD_ROI_BIT    = 15;
  localparam int OSCD_DOZE_LSB   = 12;
  localparam int OSCD_REDUCTION_ENABLE_BIT  = 11;
  localparam int OSCD_RCDIV_LSB  = 8;
  localparam int OSCD_POST_LSB   = 6;
  localparam int OSCD_PRE_LSB    = 0;

  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] OSCD_DOZE_RST  = 3'h3;
  localparam logic [2:0] OSCD_RCDIV_RST = 3'h0;
  localparam logic [1:0] OSCD_POST_RST  = 2'h1;
  localparam logic [1:0] OSCD_POST_RSVD = 2'h2;
  localparam logic [4:0] OSCD_PRE_RST   = 5'h00;
  localparam logic [1:0] OSCD_CFG_NOFSM = 2'h1;
  localparam logic [1:0] OSCD_CFG_FULL  = 2'h0;
  localparam logic [1:0] OSCD_INIT_CYC  = 2'h2;

  typedef enum logic [2:0] {
    OSCD_SRC_FAST_RC     = 3'b000,
    OSCD_SRC_FAST_RC_PLL = 3'b001,
    OSCD_SRC_PRIMARY     = 3'b010,
    OSCD_SRC_PRIMARY_PLL = 3'b011,
    OSCD_SRC_RESERVED    = 3'b100,
    OSCD_SRC_LOW_POWER   = 3'b101,
    OSCD_SRC_RC_DIV16    = 3'b110,
    OSCD_SRC_RC_DIVN     = 3'b111
  } oscd_src_type;

  typedef enum logic [1:0] {
    OSCD_SW_IDLE = 2'b00,
    OSCD_SW_WAIT = 2'b01
  } oscd_sw_state_type;

  // divider settings handed to the clock tree
  typedef struct packed {
    logic [2:0] rc_postscaler;
    logic [4:0] pll_input_divider;
    logic [1:0] pll_output_divider;
  } oscd_div_cfg_type;

endpackage

// file: sim/oscd_top_asserts.sv
// Purpose: concurrent checks on the oscd_top ports
// Assumes: one pclk domain, presetn asynchronous active low
// Notes:   attached by the bind below the module
`timescale 1ns/100ps
`default_nettype none

module oscd_top_asserts (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // straps and status
  input wire logic [1:0] switch_monitor_config,
  input wire logic       switch_done,
  // switch control
  input wire logic [2:0] current_source_sel,
  input wire logic [2:0] switch_target,
  input wire logic       switch_start,
  input wire logic       pll_in_use,
  // clock tree
  input wire oscd_pkg::oscd_div_cfg_type div_cfg,
  input wire logic       instr_clk_en,
  input wire logic       cpu_clk_en,
  // pin select
  input wire logic       pin_select_lock,
  input wire logic       pin_select_write_req,
  input wire logic       pin_select_write_grant
);
  // ----
  // settle counter, covers strap load after reset
  // ----
  logic [2:0] settle;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      settle <= 3'h0;
    else if (settle != 3'h4)
      settle <= settle + 3'h1;
  end

  // ----
  // properties
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_start_holds: assert property (switch_start && !switch_done |=> switch_start)
    else $error("switch request dropped before done");
  chk_done_update: assert property ($fell(switch_start) |-> current_source_sel == switch_target)
    else $error("current source not the target at completion");
  chk_source_stable: assert property (settle == 3'h4 && !switch_start |=> $stable(current_source_sel))
    else $error("current source moved without a switch");
  chk_no_pll_hop: assert property ($rose(switch_start) |->
    !(current_source_sel == 3'h3 && switch_target == 3'h1) &&
    !(current_source_sel == 3'h1 && switch_target == 3'h3)) else $error("direct pll hop started");
  chk_no_reserved: assert property ($rose(switch_start) |-> switch_target != 3'h4)
    else $error("switch to reserved source started");
  chk_switch_off: assert property (switch_monitor_config[1] |-> !switch_start)
    else $error("switch started with switching off");
  chk_pll_use: assert property (current_source_sel inside {3'h1, 3'h3} &&
    $stable(current_source_sel) |-> pll_in_use) else $error("pll use flag low");
  chk_grant_gate: assert property (pin_select_write_req && !pin_select_lock |=> pin_select_write_grant)
    else $error("pin select write not granted");
  chk_lock_refuse: assert property (pin_select_lock |=> !pin_select_write_grant)
    else $error("pin select write granted while locked");
  chk_instr_pace: assert property (instr_clk_en |=> !instr_clk_en ##1 instr_clk_en)
    else $error("instruction tick not every second cycle");
  chk_cpu_in_instr: assert property (cpu_clk_en |-> instr_clk_en)
    else $error("cpu tick off the instruction tick");
  chk_post_reserved: assert property (div_cfg.pll_output_divider != 2'h2)
    else $error("reserved pll output divider in use");
endmodule

bind oscd_top oscd_top_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .switch_monitor_config(switch_monitor_config),
  .switch_done(switch_done), .current_source_sel(current_source_sel),
  .switch_target(switch_target), .switch_start(switch_start), .pll_in_use(pll_in_use),
  .div_cfg(div_cfg), .instr_clk_en(instr_clk_en), .cpu_clk_en(cpu_clk_en),
  .pin_select_lock(pin_select_lock), .pin_select_write_req(pin_select_write_req),
  .pin_select_write_grant(pin_select_write_grant)
);

`default_nettype wire

// file: sim/oscd_top_tb.sv
// Purpose: directed register tests for oscd_top
// Assumes: zero-wait apb, straps steady through reset
// Notes:   monitor failure pulsed while the monitor is enabled
`timescale 1ns/100ps
`default_nettype none

module oscd_top_tb;
  // ----
  // signals
  // ----
  logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]                 paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic [2:0]                 init_src, cur_sel, sw_target;
  logic [1:0]                 mon_cfg;
  logic                       pll_locked, switch_done, irq, ps_req, sw_start, pll_use, fail_in;
  logic                       instr_en, cpu_en, ps_lock, ps_grant;
  oscd_pkg::oscd_div_cfg_type div_cfg;
  int                         miscompares, n_tests, n_instr, n_cpu;

  always #12.5 pclk = ~pclk;

  oscd_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .initial_source_config(init_src), .switch_monitor_config(mon_cfg),
    .pll_locked(pll_locked), .switch_done(switch_done), .fail_safe_monitor_fail(fail_in),
    .interrupt_event(irq), .pin_select_write_req(ps_req), .current_source_sel(cur_sel),
    .switch_target(sw_target), .switch_start(sw_start), .pll_in_use(pll_use),
    .div_cfg(div_cfg), .instr_clk_en(instr_en), .cpu_clk_en(cpu_en),
    .pin_select_lock(ps_lock), .pin_select_write_grant(ps_grant));

  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic unl(input logic [31:0] d);
    xfer(8'h08, 1'b1, 32'h0000_00a5);
    xfer(8'h08, 1'b1, 32'h0000_005a);
    xfer(8'h00, 1'b1, d);
  endtask

  task automatic sw(input logic [2:0] req, input logic [7:0] lo, input logic ok,
                    input logic [2:0] cur);
    unl({21'h0, req, lo});
    idle();
    xfer(8'h00, 1'b0, 32'h0);
    idle();
    check(rd[0], ok);
    check(sw_start, ok);
    switch_done <= 1'b1;
    repeat (6) @(posedge pclk);
    switch_done <= 1'b0;
    repeat (4) @(posedge pclk);
    xfer(8'h00, 1'b0, 32'h0);
    idle();
    check(rd[14:12], cur);
    check(cur_sel, cur);
    check(sw_target, cur);
    check(rd[0], 1'b0);
  endtask

  task automatic count(input int cyc);
    n_instr = 0;
    n_cpu = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (instr_en === 1'b1)
        n_instr++;
      if (cpu_en === 1'b1)
        n_cpu++;
    end
  endtask

  task automatic pulse_irq();
    irq <= 1'b1;
    @(posedge pclk);
    irq <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic test_done();
    $display("checks %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----
  // sequence
  // ----
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, fail_in} = '0;
    {pll_locked, switch_done, irq, ps_req, init_src, mon_cfg} = {4'h8, 3'h2, 2'h1};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    xfer(8'h00, 1'b0, 32'h0);
    check(rd, 32'h0000_2200);
    xfer(8'h04, 1'b0, 32'h0);
    check(rd, 32'h0000_3040);
    check(div_cfg, {3'h0, 5'h00, 2'h1});
    xfer(8'h0c, 1'b0, 32'h0);
    check(rd, 32'h0000_0000);
    check(err, 1'b1);
    xfer(8'h00, 1'b1, 32'h0000_0040);
    xfer(8'h08, 1'b1, 32'h0000_00a5);
    xfer(8'h08, 1'b1, 32'h0000_005a);
    xfer(8'h04, 1'b1, 32'h0000_3040);
    xfer(8'h00, 1'b1, 32'h0000_0040);
    xfer(8'h00, 1'b0, 32'h0);
    check(rd, 32'h0000_2200);
    unl(32'hffff_f074);
    xfer(8'h00, 1'b0, 32'h0);
    check(rd, 32'h0000_2040);
    idle();
    ps_req <= 1'b1;
    repeat (3) @(posedge pclk);
    check(ps_grant, 1'b0);
    check(ps_lock, 1'b1);
    unl(32'h0);
    idle();
    repeat (3) @(posedge pclk);
    check(ps_grant, 1'b1);
    check(ps_lock, 1'b0);
    ps_req <= 1'b0;
    sw(3'h0, 8'h01, 1'b1, 3'h0);
    sw(3'h3, 8'h01, 1'b1, 3'h3);
    check({rd[5], pll_use}, 2'h3);
    sw(3'h1, 8'h01, 1'b0, 3'h3);
    sw(3'h0, 8'h01, 1'b1, 3'h0);
    sw(3'h4, 8'h01, 1'b0, 3'h0);
    unl(32'h0000_0080);
    idle();
    sw(3'h2, 8'h81, 1'b0, 3'h0);
    mon_cfg <= 2'h0;
    repeat (4) @(posedge pclk);
    sw(3'h2, 8'h81, 1'b1, 3'h2);
    fail_in <= 1'b1;
    repeat (6) @(posedge pclk);
    fail_in <= 1'b0;
    xfer(8'h00, 1'b0, 32'h0);
    check(rd[3], 1'b1);
    unl(32'h0000_0200);
    xfer(8'h00, 1'b0, 32'h0);
    idle();
    check(rd[3], 1'b0);
    mon_cfg <= 2'h2;
    repeat (4) @(posedge pclk);
    sw(3'h0, 8'h01, 1'b0, 3'h2);
    mon_cfg <= 2'h1;
    xfer(8'h04, 1'b1, 32'hffff_ffff);
    xfer(8'h04, 1'b0, 32'h0);
    check(rd, 32'h0000_ffdf);
    check(div_cfg, {3'h7, 5'h1f, 2'h3});
    xfer(8'h04, 1'b1, 32'h0000_ff9f);
    xfer(8'h04, 1'b0, 32'h0);
    check(rd, 32'h0000_ffdf);
    idle();
    count(1024);
    check(n_instr, 512);
    check(n_cpu, 4);
    pulse_irq();
    xfer(8'h04, 1'b0, 32'h0);
    check(rd, 32'h0000_f7df);
    idle();
    count(64);
    check(n_cpu, 32);
    xfer(8'h04, 1'b1, 32'h0000_3840);
    idle();
    pulse_irq();
    xfer(8'h04, 1'b0, 32'h0);
    check(rd, 32'h0000_3840);
    idle();
    count(256);
    check(n_cpu, 16);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done();
  end
endmodule

`default_nettype wire
